// [sim/link_partner_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// remote partner on the twisted pair
module link_partner_model (
  input wire logic i_clk_sys,
  input wire logic [2:0] i_mode,
  input wire logic i_send,
  output var phy_ctl_pkg::line_s o_line,
  output logic [15:0] o_lcw,
  output logic o_lcw_valid
);
  logic [3:0] tick_r = 4'h0;
  wire logic silent = (i_mode == 3'h0);
  // modes: 0 silent, 1 symbols, 2 pulses, 3 both held (fault), 4 negotiating
  always_ff @(posedge i_clk_sys) begin
    tick_r <= tick_r + 4'h1;
    o_line.flp <= (i_mode == 3'h4);
    o_line.mlt3 <= i_mode[0] & ~i_mode[2];
    o_line.nlp <= i_mode[1] & (i_mode[0] | (tick_r == 4'h0));
    o_line.energy <= ~silent;
    o_line.rx_act <= i_send & ~silent;
    o_line.sig_ok <= ~silent;
    o_line.strap <= 1'b1;
    o_lcw_valid <= (i_mode == 3'h4) & (tick_r == 4'h8);
    // word holds 100 half and 10 full; garbage outside mode 4
    o_lcw <= (i_mode == 3'h4) ? 16'h00C1 : {tick_r, ~tick_r, tick_r, ~tick_r};
  end
endmodule : link_partner_model
`default_nettype wire

// [sim/phy_link_mode_power_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench top
module phy_link_mode_power_control_test;
  logic clk, rst, we, tx_en, pmt_wr, flag_clr, send;
  logic [4:0] addr;
  logic [15:0] wdata, v;
  logic [2:0] mode;
  logic [7:0] cfg;
  int num_errors = 0, n_compared = 0, cycles = 0, n;
  phy_ctl_pkg::line_s line;
  wire logic [15:0] rdata, lcw;
  wire logic lcw_valid, srst, energy, flag, irq, crs, col, no_carr, spd, fdx, link, quiet, pdown,
    tx_nlp, swap;
  phy_link_mode_power_control #(.BREAK_CYC(50), .PMT_RST_CYC(40), .BCR_RST_CYC(20),
    .NLP_TX_SHORT_CYC(10), .NLP_TX_LONG_CYC(20), .NLP_RX_SHORT_CYC(30), .NLP_RX_LONG_CYC(60))
  phy_link_mode_power_control_inst (.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_we(we), .o_reg_rdata(rdata), .i_pmt_reset_wr(pmt_wr),
    .o_phy_soft_reset_bit(srst), .i_line(line), .i_lcw(lcw), .i_lcw_valid(lcw_valid),
    .i_tx_en(tx_en), .i_mdix_disable(cfg[0]), .i_extend_xover(cfg[1]),
    .i_energy_detect_powerdown_enable(cfg[2]), .i_energy_detect_power_down_tx_nlp_en(cfg[3]),
    .i_energy_detect_power_down_tx_long(cfg[4]), .i_energy_detect_power_down_single_nlp_wake(cfg[5]), .i_energy_detect_power_down_rx_long(cfg[6]),
    .i_energy_int_en(cfg[7]), .i_energy_flag_clr(flag_clr), .o_line_energy_present(energy),
    .o_energy_event_flag(flag), .o_phy_irq(irq), .o_crs(crs), .o_col(col),
    .o_no_carrier(no_carr), .o_speed_100(spd), .o_full_duplex(fdx), .o_link_up(link),
    .o_quiet(quiet), .o_powered_down(pdown), .o_tx_nlp(tx_nlp), .o_mdi_swap(swap));
  link_partner_model link_partner_model_inst (.i_clk_sys(clk), .i_mode(mode), .i_send(send),
    .o_line(line), .o_lcw(lcw), .o_lcw_valid(lcw_valid));
  // ==========================================================
  // helpers
  task finish_test;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    cyc(2);
    d = rdata;
  endtask : rd
  task drv(input logic [2:0] m, input logic t, input logic s);
    @(posedge clk);
    mode <= m;
    tx_en <= t;
    send <= s;
  endtask : drv
  // ==========================================================
  // scenarios
  // parallel detection
  task t_parallel;
    drv(3'h0, 1'b0, 1'b0);
    cyc(8);
    drv(3'h1, 1'b0, 1'b0);
    cyc(12);
    check(link, 1'b1);
    check({spd, fdx}, 2'b10);
    rd(5'h06, v);
    check(v & 16'h0011, 16'h0000);
    rd(5'h05, v);
    check(v, 16'h0080);
    drv(3'h0, 1'b0, 1'b0);
    cyc(8);
    check(link, 1'b0);
    drv(3'h3, 1'b0, 1'b0);
    cyc(12);
    rd(5'h06, v);
    check(v[4], 1'b1);
  endtask : t_parallel
  task t_negotiate;
    drv(3'h0, 1'b0, 1'b0);
    cyc(8);
    drv(3'h4, 1'b0, 1'b0);
    cyc(30);
    check({link, spd, fdx}, 3'b110);
    rd(5'h05, v);
    check(v, 16'h00C1);
    rd(5'h06, v);
    check(v[0], 1'b1);
    wr(5'h00, 16'h1200);
    cyc(3);
    check({quiet, link}, 2'b10);
    cyc(40);
    check(quiet, 1'b1);
    cyc(45);
    check({quiet, spd, fdx}, 3'b010);
  endtask : t_negotiate
  task t_forced;
    drv(3'h2, 1'b0, 1'b0);
    wr(5'h00, 16'h0100);
    cyc(8);
    check({spd, fdx}, 2'b01);
    drv(3'h2, 1'b1, 1'b0);
    cyc(6);
    check({crs, col, no_carr}, 3'b001);
    drv(3'h2, 1'b0, 1'b1);
    cyc(6);
    check({crs, col}, 2'b10);
    drv(3'h2, 1'b1, 1'b1);
    cyc(6);
    check({crs, col}, 2'b00);
    wr(5'h00, 16'h0000);
    cyc(6);
    check({fdx, crs, col}, 3'b011);
    drv(3'h2, 1'b1, 1'b0);
    cyc(6);
    check({crs, col, no_carr}, 3'b100);
    drv(3'h2, 1'b0, 1'b0);
    cyc(6);
    check(crs, 1'b0);
  endtask : t_forced
  task t_resets;
    wr(5'h00, 16'h8000);
    rd(5'h00, v);
    check(v[15], 1'b1);
    cyc(30);
    rd(5'h00, v);
    check(v & 16'hBB00, 16'h3100);
    @(posedge clk);
    pmt_wr <= 1'b1;
    @(posedge clk);
    pmt_wr <= 1'b0;
    cyc(30);
    check(srst, 1'b1);
    cyc(15);
    check(srst, 1'b0);
    // negotiation off in the same write as power down
    wr(5'h00, 16'h0800);
    cyc(4);
    check({pdown, quiet}, 2'b11);
    wr(5'h00, 16'h0000);
    cyc(30);
    rd(5'h00, v);
    check(pdown, 1'b0);
    check(v & 16'hBB00, 16'h3100);
  endtask : t_resets
  task t_energy_detect_power_down;
    drv(3'h0, 1'b0, 1'b0);
    cfg <= 8'h1C;
    cyc(10);
    check({pdown, quiet}, 2'b11);
    n = 0;
    repeat (50) begin
      cyc(1);
      n += tx_nlp;
    end
    check(n >= 2 && n <= 3, 1'b1);
    @(posedge clk);
    cfg <= 8'hA4;
    mode <= 3'h2;
    cyc(40);
    check({energy, flag, irq, pdown}, 4'b1110);
    // clear flag, sleep again, then wake on two pulses
    @(posedge clk);
    cfg <= 8'hC4;
    mode <= 3'h0;
    flag_clr <= 1'b1;
    @(posedge clk);
    flag_clr <= 1'b0;
    cyc(10);
    check({flag, irq, pdown}, 3'b001);
    @(posedge clk);
    mode <= 3'h2;
    cyc(60);
    check({flag, irq, pdown}, 3'b110);
  endtask : t_energy_detect_power_down
  task t_xover;
    drv(3'h0, 1'b0, 1'b0);
    cfg <= 8'h01;
    cyc(2500);
    check(swap, 1'b0);
    @(posedge clk);
    cfg <= 8'h00;
    cyc(2410);
    check(swap, 1'b1);
    wr(5'h00, 16'h0000);
    @(posedge clk);
    cfg <= 8'h02;
    cyc(2500);
    check(swap, 1'b1);
    cyc(7200);
    check(swap, 1'b0);
  endtask : t_xover
  // ==========================================================
  // clock, hang guard and main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 25000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    {rst, we, tx_en, pmt_wr, flag_clr, send} = 6'b100000;
    {addr, wdata, mode, cfg} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    rd(5'h00, v);
    check(v & 16'hBB00, 16'h3100);
    rd(5'h0A, v);
    check(v, 16'h0000);
    t_negotiate();
    t_parallel();
    t_forced();
    t_resets();
    t_energy_detect_power_down();
    t_xover();
    finish_test();
  end
endmodule : phy_link_mode_power_control_test
`default_nettype wire

// [verilog/phy_ctl_pkg.sv]
`default_nettype none
package phy_ctl_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int BREAK_MS = 1250;
  localparam int BREAK_CYC = BREAK_MS * (CLK_HZ / 1000);
  localparam int PMT_RST_MS = 2;
  localparam int PMT_RST_CYC = PMT_RST_MS * (CLK_HZ / 1000);
  localparam int BCR_RST_US = 256;
  localparam int BCR_RST_CYC = BCR_RST_US * (CLK_HZ / 1_000_000);
  localparam int XOVER_US = 60;
  localparam int XOVER_CYC = XOVER_US * (CLK_HZ / 1_000_000);
  localparam int XOVER_EXT_US = 240;
  localparam int XOVER_EXT_CYC = XOVER_EXT_US * (CLK_HZ / 1_000_000);
  localparam int NLP_TX_SHORT_MS = 1;
  localparam int NLP_TX_SHORT_CYC = NLP_TX_SHORT_MS * (CLK_HZ / 1000);
  localparam int NLP_TX_LONG_MS = 2;
  localparam int NLP_TX_LONG_CYC = NLP_TX_LONG_MS * (CLK_HZ / 1000);
  localparam int NLP_RX_SHORT_MS = 16;
  localparam int NLP_RX_SHORT_CYC = NLP_RX_SHORT_MS * (CLK_HZ / 1000);
  localparam int NLP_RX_LONG_MS = 32;
  localparam int NLP_RX_LONG_CYC = NLP_RX_LONG_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 26;
  localparam int STRAP_WAIT = 3;
  // ==========================================================
  // register indices
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;
  localparam logic [4:0] REG_EXPAN = 5'h06;
  // ==========================================================
  // field positions
  localparam int B_SRST = 15;
  localparam int B_SPEED = 13;
  localparam int B_AN_EN = 12;
  localparam int B_PDOWN = 11;
  localparam int B_RESTART = 9;
  localparam int B_DUPLEX = 8;
  localparam int B_ABIL_LO = 5;
  localparam int B_ABIL_HI = 8;
  localparam int B_PD_FAULT = 4;
  localparam int B_LP_AN_ABLE = 0;
  localparam int B_TXS_NOCARR = 10;
  // ability bits within [8:5]
  localparam int A_100FD = 3;
  localparam int A_100HD = 2;
  localparam int A_10FD = 1;
  localparam int A_10HD = 0;
  // ==========================================================
  // reset values
  localparam logic RST_SPEED = 1'b1;
  localparam logic RST_AN_EN = 1'b1;
  localparam logic RST_DUPLEX = 1'b1;
  localparam logic [3:0] RST_ADV = 4'hF;
  localparam logic [4:0] SELECTOR = 5'h01;
  // ==========================================================
  // types
  typedef enum {ST_RESET, ST_PDOWN, ST_BREAK, ST_ABILITY, ST_LINK, ST_FORCED,
                ST_ENERGY_DETECT_POWER_DOWN} link_state_e;
  typedef struct packed {
    logic flp;
    logic mlt3;
    logic nlp;
    logic energy;
    logic rx_act;
    logic sig_ok;
    logic strap;
  } line_s;
endpackage : phy_ctl_pkg
`default_nettype wire

// [verilog/phy_link_mode_power_control.sv]
// Behaviour
// - no fast pulses: speed from symbols, half duplex
// - parallel link clears partner negotiation flag
// - parallel detect fault sets expansion bit four
// - partner abilities held; parallel speed written
// - restart on control bit nine or loss
// - management restart waits break link timer
// - negotiation off forces speed and duplex
// - forced bits ignored while negotiating
// - half duplex: carrier from both, collision
// - full duplex: receive while not transmitting, no collision
// - carrier high on activity, low otherwise
// - no carrier flag from internal carrier
// - crossover swap, disabled by bit or strap
// - extended crossover time in forced modes
// - power down bit; clearing resets phy
// - energy power down transmits only optional pulses
// - energy wakes, restores state, sets flag
// - enabled energy flag raises interrupt
// - optional pulses sent; one or two wake
// - power control reset bit clears after 2 ms
// - control bit fifteen reset, 256 us
// - ability priority 100FD,100HD,10FD,10HD
// - advertised bits from register four
`timescale 1ns/1ps
`default_nettype none
module phy_link_mode_power_control #(
  parameter int BREAK_CYC = phy_ctl_pkg::BREAK_CYC,
  parameter int PMT_RST_CYC = phy_ctl_pkg::PMT_RST_CYC,
  parameter int BCR_RST_CYC = phy_ctl_pkg::BCR_RST_CYC,
  parameter int NLP_TX_SHORT_CYC = phy_ctl_pkg::NLP_TX_SHORT_CYC,
  parameter int NLP_TX_LONG_CYC = phy_ctl_pkg::NLP_TX_LONG_CYC,
  parameter int NLP_RX_SHORT_CYC = phy_ctl_pkg::NLP_RX_SHORT_CYC,
  parameter int NLP_RX_LONG_CYC = phy_ctl_pkg::NLP_RX_LONG_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [4:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_we,
  output logic [15:0] o_reg_rdata,
  input wire logic i_pmt_reset_wr,
  output logic o_phy_soft_reset_bit,
  input wire phy_ctl_pkg::line_s i_line,
  input wire logic [15:0] i_lcw,
  input wire logic i_lcw_valid,
  input wire logic i_tx_en,
  input wire logic i_mdix_disable,
  input wire logic i_extend_xover,
  input wire logic i_energy_detect_powerdown_enable,
  input wire logic i_energy_detect_power_down_tx_nlp_en,
  input wire logic i_energy_detect_power_down_tx_long,
  input wire logic i_energy_detect_power_down_single_nlp_wake,
  input wire logic i_energy_detect_power_down_rx_long,
  input wire logic i_energy_int_en,
  input wire logic i_energy_flag_clr,
  output logic o_line_energy_present,
  output logic o_energy_event_flag,
  output logic o_phy_irq,
  output logic o_crs,
  output logic o_col,
  output logic o_no_carrier,
  output logic o_speed_100,
  output logic o_full_duplex,
  output logic o_link_up,
  output logic o_quiet,
  output logic o_powered_down,
  output logic o_tx_nlp,
  output logic o_mdi_swap
);
  // ==========================================================
  // line synchroniser
  phy_ctl_pkg::line_s ln_a_r, ln_r, ln_d_r;
  always_ff @(posedge i_clk_sys) begin
    ln_a_r <= i_line;
    ln_r <= ln_a_r;
    ln_d_r <= ln_r;
  end
  wire nlp_pulse = ln_r.nlp & ~ln_d_r.nlp;

  // ==========================================================
  // state and registers
  phy_ctl_pkg::link_state_e st_r, st_nxt, saved_r;
  logic [phy_ctl_pkg::CNT_W-1:0] cnt_r, rst_len_r;
  logic speed_r, an_en_r, pdown_r, duplex_r, bcr_busy_r, pmt_busy_r;
  logic [3:0] adv_r;
  logic [15:0] partner_r;
  logic pd_fault_r, lp_able_r, res_spd_r, res_dup_r, seen1_r;
  logic strap_r, flag_r;
  logic [1:0] strap_cnt_r;

  // write decode
  wire wr_ctrl = i_reg_we & (i_reg_addr == phy_ctl_pkg::REG_CTRL);
  wire wr_adv = i_reg_we & (i_reg_addr == phy_ctl_pkg::REG_ADV);
  wire wr_srst = wr_ctrl & i_reg_wdata[phy_ctl_pkg::B_SRST];
  wire wr_pdown = wr_ctrl & i_reg_wdata[phy_ctl_pkg::B_PDOWN];
  wire wr_an_en = i_reg_wdata[phy_ctl_pkg::B_AN_EN];
  wire wr_restart = wr_ctrl & i_reg_wdata[phy_ctl_pkg::B_RESTART] & wr_an_en;
  wire in_reset = (st_r == phy_ctl_pkg::ST_RESET);
  // power down cleared: automatic soft reset
  wire pd_wake = (st_r == phy_ctl_pkg::ST_PDOWN) & ~pdown_r;
  wire rst_done = in_reset & (cnt_r == rst_len_r);
  wire active = (st_r == phy_ctl_pkg::ST_ABILITY) | (st_r == phy_ctl_pkg::ST_LINK) |
                (st_r == phy_ctl_pkg::ST_FORCED);

  wire [3:0] common = adv_r & i_lcw[phy_ctl_pkg::B_ABIL_HI:phy_ctl_pkg::B_ABIL_LO];
  wire an_spd = common[phy_ctl_pkg::A_100FD] | common[phy_ctl_pkg::A_100HD];
  wire an_dup = common[phy_ctl_pkg::A_100FD] |
                (~common[phy_ctl_pkg::A_100HD] & common[phy_ctl_pkg::A_10FD]);
  wire lcw_ok = i_lcw_valid & (common != 4'h0);
  wire par_one = ~ln_r.flp & (ln_r.mlt3 ^ ln_r.nlp);
  wire par_fault = ~ln_r.flp & ln_r.mlt3 & ln_r.nlp;
  wire in_able = (st_r == phy_ctl_pkg::ST_ABILITY);

  wire [phy_ctl_pkg::CNT_W-1:0] rx_win = i_energy_detect_power_down_rx_long ?
    phy_ctl_pkg::CNT_W'(NLP_RX_LONG_CYC) : phy_ctl_pkg::CNT_W'(NLP_RX_SHORT_CYC);
  wire in_energy_detect_power_down = (st_r == phy_ctl_pkg::ST_ENERGY_DETECT_POWER_DOWN);
  wire wake = in_energy_detect_power_down & ln_r.energy & nlp_pulse &
              (i_energy_detect_power_down_single_nlp_wake | (seen1_r & (cnt_r <= rx_win)));

  // next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      phy_ctl_pkg::ST_RESET: begin
        if (rst_done) begin
          if (pdown_r) begin
            st_nxt = phy_ctl_pkg::ST_PDOWN;
          end else if (an_en_r) begin
            st_nxt = phy_ctl_pkg::ST_ABILITY;
          end else begin
            st_nxt = phy_ctl_pkg::ST_FORCED;
          end
        end
      end
      phy_ctl_pkg::ST_PDOWN: begin
        if (!pdown_r) begin
          st_nxt = phy_ctl_pkg::ST_RESET;
        end
      end
      phy_ctl_pkg::ST_BREAK: begin
        if (cnt_r == phy_ctl_pkg::CNT_W'(BREAK_CYC - 1)) begin
          st_nxt = phy_ctl_pkg::ST_ABILITY;
        end
      end
      phy_ctl_pkg::ST_ABILITY: begin
        if (lcw_ok || par_one) begin
          st_nxt = phy_ctl_pkg::ST_LINK;
        end
      end
      phy_ctl_pkg::ST_LINK: begin
        if (!ln_r.sig_ok) begin
          st_nxt = phy_ctl_pkg::ST_ABILITY;
        end
      end
      phy_ctl_pkg::ST_ENERGY_DETECT_POWER_DOWN: begin
        if (wake) begin
          st_nxt = saved_r;
        end
      end
      default: st_nxt = st_r;
    endcase
    if (active) begin
      if (wr_ctrl && !wr_an_en) begin
        st_nxt = phy_ctl_pkg::ST_FORCED;
      end else if (wr_restart) begin
        st_nxt = phy_ctl_pkg::ST_BREAK;
      end else if (wr_ctrl && st_r == phy_ctl_pkg::ST_FORCED) begin
        st_nxt = phy_ctl_pkg::ST_ABILITY;
      end else if (i_energy_detect_powerdown_enable && !ln_r.energy) begin
        st_nxt = phy_ctl_pkg::ST_ENERGY_DETECT_POWER_DOWN;
      end
    end
    if (wr_pdown && !in_reset) begin
      st_nxt = phy_ctl_pkg::ST_PDOWN;
    end
    if (i_pmt_reset_wr || wr_srst) begin
      st_nxt = phy_ctl_pkg::ST_RESET;
    end
  end

  // state register and shared counter
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= phy_ctl_pkg::ST_RESET;
      saved_r <= phy_ctl_pkg::ST_ABILITY;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt == phy_ctl_pkg::ST_ENERGY_DETECT_POWER_DOWN && active) begin
        saved_r <= st_r;
      end
      if (st_nxt != st_r || (in_energy_detect_power_down && nlp_pulse)) begin
        cnt_r <= '0;
      end else if (cnt_r != '1) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rst_len_r <= '0;
      bcr_busy_r <= 1'b0;
      pmt_busy_r <= 1'b0;
    end else if (i_pmt_reset_wr) begin
      rst_len_r <= phy_ctl_pkg::CNT_W'(PMT_RST_CYC - 1);
      pmt_busy_r <= 1'b1;
    end else if (wr_srst || pd_wake) begin
      rst_len_r <= phy_ctl_pkg::CNT_W'(BCR_RST_CYC - 1);
      bcr_busy_r <= wr_srst;
    end else if (rst_done) begin
      bcr_busy_r <= 1'b0;
      pmt_busy_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_pmt_reset_wr || wr_srst || pd_wake) begin
      speed_r <= phy_ctl_pkg::RST_SPEED;
      an_en_r <= phy_ctl_pkg::RST_AN_EN;
      duplex_r <= phy_ctl_pkg::RST_DUPLEX;
      pdown_r <= 1'b0;
    end else if (wr_ctrl && !in_reset) begin
      speed_r <= i_reg_wdata[phy_ctl_pkg::B_SPEED];
      an_en_r <= wr_an_en;
      duplex_r <= i_reg_wdata[phy_ctl_pkg::B_DUPLEX];
      pdown_r <= i_reg_wdata[phy_ctl_pkg::B_PDOWN];
    end
    if (i_rst || i_pmt_reset_wr) begin
      adv_r <= phy_ctl_pkg::RST_ADV;
    end else if (wr_adv) begin
      adv_r <= i_reg_wdata[phy_ctl_pkg::B_ABIL_HI:phy_ctl_pkg::B_ABIL_LO];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_pmt_reset_wr || wr_srst || pd_wake) begin
      partner_r <= '0;
      pd_fault_r <= 1'b0;
      lp_able_r <= 1'b0;
      res_spd_r <= 1'b0;
      res_dup_r <= 1'b0;
    end else if (in_able && lcw_ok) begin
      partner_r <= i_lcw;
      lp_able_r <= 1'b1;
      res_spd_r <= an_spd;
      res_dup_r <= an_dup;
    end else if (in_able && par_one) begin
      partner_r <= '0;
      partner_r[phy_ctl_pkg::B_ABIL_LO + phy_ctl_pkg::A_100HD] <= ln_r.mlt3;
      partner_r[phy_ctl_pkg::B_ABIL_LO + phy_ctl_pkg::A_10HD] <= ln_r.nlp;
      lp_able_r <= 1'b0;
      res_spd_r <= ln_r.mlt3;
      res_dup_r <= 1'b0;
    end else if (in_able && par_fault) begin
      pd_fault_r <= 1'b1;
    end
  end

  wire op_spd = an_en_r ? res_spd_r : speed_r;
  wire op_dup = an_en_r ? res_dup_r : duplex_r;
  wire link = (st_r == phy_ctl_pkg::ST_LINK) |
              ((st_r == phy_ctl_pkg::ST_FORCED) & ln_r.sig_ok);
  wire quiet = ~active;
  wire rx_act = ln_r.rx_act & ~quiet;
  // no data goes out while quiet, so no transmit carrier then
  wire tx_act = i_tx_en & ~quiet;
  wire crs_nxt = op_dup ? (rx_act & ~tx_act) : (rx_act | tx_act);
  wire col_nxt = ~op_dup & tx_act & rx_act;

  // mode and carrier outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_crs <= 1'b0;
      o_col <= 1'b0;
      o_no_carrier <= 1'b0;
      o_speed_100 <= 1'b0;
      o_full_duplex <= 1'b0;
      o_link_up <= 1'b0;
    end else begin
      o_crs <= crs_nxt;
      o_col <= col_nxt;
      o_no_carrier <= i_tx_en & ~crs_nxt;
      o_speed_100 <= op_spd;
      o_full_duplex <= op_dup;
      o_link_up <= link;
    end
  end

  // ==========================================================
  // crossover
  logic [phy_ctl_pkg::CNT_W-1:0] xo_cnt_r;
  wire forced = (st_r == phy_ctl_pkg::ST_FORCED);
  wire [phy_ctl_pkg::CNT_W-1:0] xo_len = (forced && i_extend_xover) ?
    phy_ctl_pkg::CNT_W'(phy_ctl_pkg::XOVER_EXT_CYC - 1) :
    phy_ctl_pkg::CNT_W'(phy_ctl_pkg::XOVER_CYC - 1);
  wire mdix_on = ~i_mdix_disable & strap_r & active & ~link;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !mdix_on) begin
      xo_cnt_r <= '0;
    end else if (xo_cnt_r >= xo_len) begin
      xo_cnt_r <= '0;
    end else begin
      xo_cnt_r <= xo_cnt_r + 1'b1;
    end
    if (i_rst || (i_mdix_disable | ~strap_r)) begin
      o_mdi_swap <= 1'b0;
    end else if (mdix_on && xo_cnt_r >= xo_len) begin
      o_mdi_swap <= ~o_mdi_swap;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      strap_cnt_r <= '0;
      strap_r <= 1'b0;
    end else if (strap_cnt_r != 2'(phy_ctl_pkg::STRAP_WAIT)) begin
      strap_cnt_r <= strap_cnt_r + 1'b1;
      strap_r <= ln_r.strap;
    end
  end

  // ==========================================================
  // energy power down
  logic [phy_ctl_pkg::CNT_W-1:0] nlp_cnt_r;
  wire [phy_ctl_pkg::CNT_W-1:0] tx_int = i_energy_detect_power_down_tx_long ?
    phy_ctl_pkg::CNT_W'(NLP_TX_LONG_CYC - 1) : phy_ctl_pkg::CNT_W'(NLP_TX_SHORT_CYC - 1);
  wire nlp_due = in_energy_detect_power_down & i_energy_detect_power_down_tx_nlp_en & (nlp_cnt_r >= tx_int);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !in_energy_detect_power_down || nlp_due) begin
      nlp_cnt_r <= '0;
    end else begin
      nlp_cnt_r <= nlp_cnt_r + 1'b1;
    end
    if (i_rst || !in_energy_detect_power_down) begin
      seen1_r <= 1'b0;
    end else if (nlp_pulse) begin
      seen1_r <= 1'b1;
    end
    o_tx_nlp <= ~i_rst & nlp_due;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flag_r <= 1'b0;
    end else if (wake) begin
      flag_r <= 1'b1;
    end else if (i_energy_flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  assign o_energy_event_flag = flag_r;
  assign o_phy_irq = flag_r & i_energy_int_en;
  assign o_line_energy_present = ln_r.energy;
  assign o_quiet = quiet;
  assign o_powered_down = in_energy_detect_power_down | (st_r == phy_ctl_pkg::ST_PDOWN);
  assign o_phy_soft_reset_bit = pmt_busy_r;

  // ==========================================================
  // register read
  wire [15:0] rd_ctrl = {bcr_busy_r, 1'b0, speed_r, an_en_r, pdown_r, 2'h0, duplex_r, 8'h00};
  wire [15:0] rd_adv = {7'h00, adv_r, phy_ctl_pkg::SELECTOR};
  wire [15:0] rd_exp = {11'h000, pd_fault_r, 3'h0, lp_able_r};
  wire [15:0] rd_mux = (i_reg_addr == phy_ctl_pkg::REG_CTRL) ? rd_ctrl :
                       (i_reg_addr == phy_ctl_pkg::REG_ADV) ? rd_adv :
                       (i_reg_addr == phy_ctl_pkg::REG_PARTNER) ? partner_r :
                       (i_reg_addr == phy_ctl_pkg::REG_EXPAN) ? rd_exp : 16'h0000;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_rdata <= '0;
    end else begin
      o_reg_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // checks
  property p_restart;
    @(posedge i_clk_sys) disable iff (i_rst)
      (active && wr_restart && !i_pmt_reset_wr && !wr_srst && !wr_pdown && wr_ctrl)
      |=> st_r == phy_ctl_pkg::ST_BREAK;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not break link");
  property p_break;
    @(posedge i_clk_sys) disable iff (i_rst)
      $rose(st_r == phy_ctl_pkg::ST_BREAK) |-> ##1 quiet [*3];
  endproperty
  a_break: assert property (p_break) else $error("activity during break");
  property p_par;
    @(posedge i_clk_sys) disable iff (i_rst)
      (in_able && !lcw_ok && par_one && !i_pmt_reset_wr && !wr_srst)
      |=> !lp_able_r && !res_dup_r && res_spd_r == $past(ln_r.mlt3);
  endproperty
  a_par: assert property (p_par) else $error("parallel detect result wrong");
  property p_fault;
    @(posedge i_clk_sys) disable iff (i_rst)
      (in_able && !lcw_ok && par_fault && !i_pmt_reset_wr && !wr_srst) |=> pd_fault_r;
  endproperty
  a_fault: assert property (p_fault) else $error("fault bit not set");
  property p_fd;
    @(posedge i_clk_sys) disable iff (i_rst)
      (op_dup && i_tx_en) |=> !o_crs && !o_col;
  endproperty
  a_fd: assert property (p_fd) else $error("full duplex carrier on transmit");
  property p_hd;
    @(posedge i_clk_sys) disable iff (i_rst)
      (!op_dup && i_tx_en && rx_act) |=> o_crs && o_col;
  endproperty
  a_hd: assert property (p_hd) else $error("half duplex collision missed");
  property p_pdown;
    @(posedge i_clk_sys) disable iff (i_rst)
      (st_r == phy_ctl_pkg::ST_PDOWN && !pdown_r) |=> in_reset && rst_len_r == phy_ctl_pkg::CNT_W'(BCR_RST_CYC - 1);
  endproperty
  a_pdown: assert property (p_pdown) else $error("power up without reset");
  property p_energy_detect_power_down;
    @(posedge i_clk_sys) disable iff (i_rst)
      in_energy_detect_power_down |=> !o_crs && (o_tx_nlp -> i_energy_detect_power_down_tx_nlp_en);
  endproperty
  a_energy_detect_power_down: assert property (p_energy_detect_power_down) else $error("activity in energy power down");
  property p_srst;
    @(posedge i_clk_sys) disable iff (i_rst)
      (wr_srst && !i_pmt_reset_wr) |=> bcr_busy_r ##1 o_reg_rdata[phy_ctl_pkg::B_SRST] || i_reg_addr != phy_ctl_pkg::REG_CTRL;
  endproperty
  a_srst: assert property (p_srst) else $error("reset bit not read as one");
  property p_irq;
    @(posedge i_clk_sys) disable iff (i_rst)
      (wake && i_energy_int_en) |=> o_phy_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("energy interrupt missing");
endmodule : phy_link_mode_power_control
`default_nettype wire
